// *** core/bsx_unit.sv ***
// Bit scan and register exchange execution slice with its working register file.
`timescale 1ns/1ps
module bsx_unit
    import bsx_pkg::*;
#(
    parameter int unsigned NREG = BSX_NREG
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [15:0] mem_rdata,
    output bsx_mem_req_t mem_req,
    output logic instr_taken,
    output logic carry_flag,
    output logic [15:0] wreg_view [NREG],
    output logic [15:0] last_result
);

    logic [15:0] wreg_q [NREG];
    logic carry_q;
    logic [15:0] result_q;
    bsx_op_t op;
    logic [3:0] dst;
    logic [3:0] src;
    logic [2:0] mode;
    logic [15:0] ptr;
    logic [15:0] operand;
    logic [15:0] scan_val;
    logic scan_none;
    logic scan_op;
    logic [15:0] scl_diff;
    logic [4:0] scl_pos;
    logic [4:0] left_pos;
    logic [4:0] right_pos;
    logic wr_dst_en;
    logic wr_src_en;
    logic [15:0] wr_dst_d;
    logic [15:0] wr_src_d;

    // The three scans read an operand and write carry; swap does neither.
    function automatic logic is_scan(input bsx_op_t o);
        logic s;
        s = 1'b0;
        case (o)
            BSX_OP_SCL: s = 1'b1;
            BSX_OP_FL: s = 1'b1;
            BSX_OP_FR: s = 1'b1;
            default: s = 1'b0;
        endcase
        return s;
    endfunction : is_scan

    // Only the six defined source modes are accepted.
    function automatic logic mode_ok(input logic [2:0] m);
        logic ok;
        ok = 1'b0;
        case (m)
            BSX_AM_DIRECT, BSX_AM_IND: ok = 1'b1;
            BSX_AM_POSTDEC, BSX_AM_POSTINC: ok = 1'b1;
            BSX_AM_PREDEC, BSX_AM_PREINC: ok = 1'b1;
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : mode_ok

    // Full opcode match, so a word that only shares the upper bits is refused.
    function automatic bsx_op_t decode_op(input logic [23:0] w);
        bsx_op_t o;
        o = BSX_OP_NONE;
        if (w[23:BSX_SWAP_PFX_LSB] == BSX_SWAP_PFX
            && w[BSX_PFX_LSB +: 4] == 4'h0
            && w[BSX_MODE_LSB +: 3] == BSX_SWAP_MID) begin
            o = BSX_OP_SWAP;
        end else if (w[23:BSX_PFX_LSB] == BSX_SCL_PFX) begin
            o = BSX_OP_SCL;
        end else if (w[23:BSX_PFX_LSB] == BSX_FL_PFX) begin
            o = BSX_OP_FL;
        end else if (w[23:BSX_PFX_LSB] == BSX_FR_PFX) begin
            o = BSX_OP_FR;
        end
        if (is_scan(o) && !mode_ok(w[BSX_MODE_LSB +: 3])) begin
            o = BSX_OP_NONE;
        end
        return o;
    endfunction : decode_op

    // Pointer after the post or pre step of the source mode.
    function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic [2:0] m);
        logic [15:0] q;
        q = p;
        case (m)
            BSX_AM_POSTINC, BSX_AM_PREINC: q = p + BSX_PTR_STEP;
            BSX_AM_POSTDEC, BSX_AM_PREDEC: q = p - BSX_PTR_STEP;
            default: q = p;
        endcase
        return q;
    endfunction : step_ptr

    // Pre modes address the stepped pointer, all others the pointer itself.
    function automatic logic [15:0] eff_addr(input logic [15:0] p, input logic [2:0] m);
        logic [15:0] a;
        a = p;
        case (m)
            BSX_AM_PREDEC, BSX_AM_PREINC: a = step_ptr(p, m);
            default: a = p;
        endcase
        return a;
    endfunction : eff_addr

    // Index of the first one from the left, 1 for the MSB, 0 if none.
    function automatic logic [4:0] first_one_left(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (n == 5'h00 && v[15 - i]) begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction : first_one_left

    // Index of the first one from the right, 1 for the LSB, 0 if none.
    function automatic logic [4:0] first_one_right(input logic [15:0] v);
        logic [4:0] n;
        n = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (n == 5'h00 && v[i]) begin
                n = 5'(i + 1);
            end
        end
        return n;
    endfunction : first_one_right

    // Marks every bit below the sign that differs from it; bit 0 is never marked.
    function automatic logic [15:0] scl_marks(input logic [15:0] v);
        return {v[14:0] ^ {15{v[15]}}, 1'b0};
    endfunction : scl_marks

    // Negated count of sign copies, or the no-change value.
    function automatic logic [15:0] scl_value(input logic [4:0] n);
        logic [15:0] r;
        r = BSX_SCL_NONE;
        if (n != 5'h00) begin
            r = 16'(-$signed({11'h000, n - 5'h01}));
        end
        return r;
    endfunction : scl_value

    // Zero-extended bit number; a miss gives the none value.
    function automatic logic [15:0] one_value(input logic [4:0] n);
        return (n == 5'h00) ? BSX_ONE_NONE : {11'h000, n};
    endfunction : one_value

    // Instruction fields.
    always_comb begin
        dst = instr_word[BSX_DST_LSB +: 4];
        src = instr_word[BSX_SRC_LSB +: 4];
        mode = instr_word[BSX_MODE_LSB +: 3];
    end

    // Decode only while an instruction is presented.
    always_comb begin
        op = BSX_OP_NONE;
        if (instr_valid) begin
            op = decode_op(instr_word);
        end
        scan_op = is_scan(op);
    end

    // Effective address and memory read for indirect source modes.
    always_comb begin
        ptr = eff_addr(wreg_q[src], mode);
        mem_req.rd = scan_op && mode != BSX_AM_DIRECT;
        mem_req.addr = ptr;
    end

    always_comb begin
        operand = wreg_q[src];
        if (mem_req.rd) begin
            operand = mem_rdata;
        end
    end

    // Bit positions of all three scans, computed side by side.
    always_comb begin
        scl_diff = scl_marks(operand);
        scl_pos = first_one_left(scl_diff);
        left_pos = first_one_left(operand);
        right_pos = first_one_right(operand);
    end

    // Result and carry of the selected scan.
    always_comb begin
        scan_val = BSX_ONE_NONE;
        scan_none = 1'b0;
        case (op)
            BSX_OP_SCL: begin
                scan_val = scl_value(scl_pos);
                scan_none = (scl_pos == 5'h00);
            end
            BSX_OP_FL: begin
                scan_val = one_value(left_pos);
                scan_none = (left_pos == 5'h00);
            end
            BSX_OP_FR: begin
                scan_val = one_value(right_pos);
                scan_none = (right_pos == 5'h00);
            end
            default: begin
                scan_val = BSX_ONE_NONE;
                scan_none = 1'b0;
            end
        endcase
    end

    // Write ports of the register file; the destination port is applied last.
    always_comb begin
        wr_dst_en = 1'b0;
        wr_dst_d = wreg_q[dst];
        wr_src_en = 1'b0;
        wr_src_d = wreg_q[src];
        case (op)
            BSX_OP_SWAP: begin
                wr_dst_en = 1'b1;
                wr_dst_d = wreg_q[src];
                wr_src_en = 1'b1;
                wr_src_d = wreg_q[dst];
            end
            BSX_OP_SCL, BSX_OP_FL, BSX_OP_FR: begin
                wr_dst_en = 1'b1;
                wr_dst_d = scan_val;
                wr_src_en = 1'b1;
                wr_src_d = step_ptr(wreg_q[src], mode);
            end
            default: begin
                wr_dst_en = 1'b0;
                wr_dst_d = wreg_q[dst];
                wr_src_en = 1'b0;
                wr_src_d = wreg_q[src];
            end
        endcase
    end

    // Working registers, written on the clock edge that ends the instruction's cycle.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            for (int i = 0; i < NREG; i++) begin
                wreg_q[i] <= 16'h0000;
            end
        end else begin
            if (wr_src_en) begin
                wreg_q[src] <= wr_src_d;
            end
            if (wr_dst_en) begin
                wreg_q[dst] <= wr_dst_d;
            end
        end
    end

    // Carry is left alone by swap and written by every scan.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            carry_q <= BSX_RST_C;
        end else if (scan_op) begin
            carry_q <= scan_none;
        end
    end

    // Last scan result, held until the next scan.
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            result_q <= 16'h0000;
        end else if (scan_op) begin
            result_q <= scan_val;
        end
    end

    assign instr_taken = (op != BSX_OP_NONE);
    assign carry_flag = carry_q;
    assign last_result = result_q;
    assign wreg_view = wreg_q;

endmodule : bsx_unit

// *** core/bsx_pkg.sv ***
// Package with encodings, field positions and types of the bit scan and exchange unit.
package bsx_pkg;

    localparam int unsigned BSX_W = 16;
    localparam int unsigned BSX_NREG = 16;

    // Opcode prefixes in instruction bits 23:15 and 23:11.
    localparam logic [8:0] BSX_SWAP_PFX = 9'h1FA;
    localparam logic [12:0] BSX_SCL_PFX = 13'h1BE0;
    localparam logic [12:0] BSX_FL_PFX = 13'h1DF0;
    localparam logic [12:0] BSX_FR_PFX = 13'h19E0;
    localparam int unsigned BSX_DST_LSB = 7;
    localparam int unsigned BSX_MODE_LSB = 4;
    localparam int unsigned BSX_SRC_LSB = 0;
    localparam int unsigned BSX_PFX_LSB = 11;
    localparam int unsigned BSX_SWAP_PFX_LSB = 15;
    localparam logic [2:0] BSX_SWAP_MID = 3'h0;

    // Source addressing modes.
    localparam logic [2:0] BSX_AM_DIRECT = 3'h0;
    localparam logic [2:0] BSX_AM_IND = 3'h1;
    localparam logic [2:0] BSX_AM_POSTDEC = 3'h2;
    localparam logic [2:0] BSX_AM_POSTINC = 3'h3;
    localparam logic [2:0] BSX_AM_PREDEC = 3'h4;
    localparam logic [2:0] BSX_AM_PREINC = 3'h5;
    localparam logic [15:0] BSX_PTR_STEP = 16'h0002;

    // Results of scans that find nothing, and the sign-change scan limit.
    localparam logic [15:0] BSX_SCL_NONE = 16'hFFF1;
    localparam logic [15:0] BSX_ONE_NONE = 16'h0000;
    localparam int unsigned BSX_SCL_MAX = 15;
    localparam logic BSX_RST_C = 1'b0;

    typedef enum logic [2:0] {
        BSX_OP_NONE = 3'b000,
        BSX_OP_SWAP = 3'b001,
        BSX_OP_SCL = 3'b010,
        BSX_OP_FL = 3'b011,
        BSX_OP_FR = 3'b100
    } bsx_op_t;

    // Memory operand request towards the data path.
    typedef struct packed {
        logic rd;
        logic [15:0] addr;
    } bsx_mem_req_t;

endpackage : bsx_pkg

// *** bench/bsx_properties.sv ***
// Port assertions for the bit scan and exchange unit.
`timescale 1ns/1ps
module bsx_properties
    import bsx_pkg::*;
#(
    parameter int unsigned NREG = BSX_NREG
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic instr_valid,
    input wire logic [23:0] instr_word,
    input wire logic [15:0] mem_rdata,
    input wire bsx_mem_req_t mem_req,
    input wire logic instr_taken,
    input wire logic carry_flag,
    input wire logic [15:0] wreg_view [NREG],
    input wire logic [15:0] last_result
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    logic [15:0] opnd_q, a_q, b_q;
    logic [3:0] d_q, s_q;
    wire [12:0] pfx = instr_word[23:11];
    wire [15:0] opnd = instr_word[6:4] == BSX_AM_DIRECT ? wreg_view[instr_word[3:0]] : mem_rdata;
    wire sw = instr_valid && pfx == {BSX_SWAP_PFX, 4'h0} && instr_word[6:4] == 3'h0;
    wire fl = instr_valid && instr_taken && pfx == BSX_FL_PFX;
    wire fr = instr_valid && instr_taken && pfx == BSX_FR_PFX;
    wire scl = instr_valid && instr_taken && pfx == BSX_SCL_PFX;
    always_ff @(posedge sys_clk) begin
        opnd_q <= opnd;
        a_q <= wreg_view[instr_word[10:7]];
        b_q <= wreg_view[instr_word[3:0]];
        d_q <= instr_word[10:7];
        s_q <= instr_word[3:0];
    end
    AST_SWAP_TAKE: assert property (sw |-> instr_taken) else $error("swap refused");
    AST_SWAP_XCHG: assert property (sw |=> wreg_view[d_q] == b_q && wreg_view[s_q] == a_q)
        else $error("swap did not exchange");
    AST_SWAP_FLAG: assert property (sw |=> $stable(carry_flag)) else $error("swap moved carry");
    AST_SWAP_NOMEM: assert property (sw |-> !mem_req.rd) else $error("swap read memory");
    AST_BAD_MODE: assert property (instr_word[6:4] > BSX_AM_PREINC |-> !instr_taken) else $error("bad mode");
    AST_IND_READ: assert property (instr_valid && instr_taken && pfx[12:4] != BSX_SWAP_PFX
        && instr_word[6:4] != 3'h0 |-> mem_req.rd) else $error("no memory read");
    AST_FL_CARRY: assert property (fl |=> carry_flag == (opnd_q == 16'h0000)) else $error("left carry");
    AST_FR_CARRY: assert property (fr |=> carry_flag == (opnd_q == 16'h0000)) else $error("right carry");
    AST_SCL_NONE: assert property (scl && (opnd == 16'h0000 || opnd == 16'hFFFF)
        |=> carry_flag && last_result == BSX_SCL_NONE) else $error("sign scan none");
    AST_ONE_NONE: assert property ((fl || fr) && opnd == 16'h0000 |=> last_result == BSX_ONE_NONE)
        else $error("one scan none");
    AST_FL_MSB: assert property (fl && opnd[15] |=> last_result == 16'h0001) else $error("left msb");
endmodule : bsx_properties
bind bsx_unit bsx_properties #(.NREG(NREG)) u_props(.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .mem_rdata(mem_rdata), .mem_req(mem_req), .instr_taken(instr_taken),
    .carry_flag(carry_flag), .wreg_view(wreg_view), .last_result(last_result));

// *** bench/testbench.sv ***
// Self-checking testbench of the bit scan and exchange unit.
`timescale 1ns/1ps
module testbench;
    import bsx_pkg::*;
    logic sys_clk = 0, rst_n = 0, instr_valid = 0, instr_taken, carry_flag;
    logic [23:0] instr_word = '0;
    logic [15:0] mem_rdata = '0, last_result;
    logic [15:0] wreg_view [BSX_NREG];
    bsx_mem_req_t mem_req;
    int num_errors = 0, checks_done = 0, cycles = 0;
    bsx_unit uut(.sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .mem_rdata(mem_rdata), .mem_req(mem_req), .instr_taken(instr_taken), .carry_flag(carry_flag),
        .wreg_view(wreg_view), .last_result(last_result));
    initial forever #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (++cycles > 2000) begin
            num_errors++;
            end_of_test();
        end
    end
    task automatic end_of_test;
        if (num_errors == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input string n, input logic [15:0] e, g);
        checks_done++;
        if (g !== e) begin
            num_errors++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask : chk
    function automatic logic [23:0] enc(input logic [12:0] p, input logic [2:0] m, input logic [3:0] d, s);
        return {p, 11'h000} | {13'h0000, d, m, s};
    endfunction : enc
    task automatic op(input logic [23:0] w, input logic [15:0] rd, input logic t);
        @(posedge sys_clk);
        #1;
        instr_valid = 1'b1;
        instr_word = w;
        mem_rdata = rd;
        #1 chk("taken", {15'h0, t}, {15'h0, instr_taken});
    endtask : op
    task automatic done;
        @(posedge sys_clk);
        #1 instr_valid = 1'b0;
    endtask : done
    task automatic sc(input logic [12:0] p, input logic [15:0] v, r, input logic c);
        op(enc(p, BSX_AM_IND, 4'h5, 4'h1), v, 1'b1);
        chk("rd", 16'h0001, {15'h0, mem_req.rd});
        done();
        chk("res", r, wreg_view[5]);
        chk("last", r, last_result);
        chk("carry", {15'h0, c}, {15'h0, carry_flag});
    endtask : sc
    task automatic pt(input logic [2:0] m, input logic [15:0] a, w2);
        op(enc(BSX_FR_PFX, m, 4'h6, 4'h2), 16'h0001, 1'b1);
        chk("addr", a, mem_req.addr);
        done();
        chk("ptr", w2, wreg_view[2]);
    endtask : pt
    task automatic t_swap;
        op(enc({BSX_SWAP_PFX, 4'h0}, 3'h0, 4'h5, 4'h9), 16'h0000, 1'b1);
        op(enc({BSX_SWAP_PFX, 4'h0}, 3'h0, 4'h9, 4'h3), 16'h0000, 1'b1);
        op(enc({BSX_SWAP_PFX, 4'h0}, 3'h1, 4'h3, 4'h5), 16'h0000, 1'b0);
        op(enc(BSX_FL_PFX, 3'h6, 4'h3, 4'h5), 16'h0000, 1'b0);
        op(enc({BSX_SWAP_PFX, 4'h1}, 3'h0, 4'h3, 4'h5), 16'h0000, 1'b0);
        done();
        chk("w3", 16'hFFF1, wreg_view[3]);
        chk("w5", 16'h0000, wreg_view[5]);
        chk("c", 16'h0001, {15'h0, carry_flag});
    endtask : t_swap
    task automatic t_direct;
        op(enc(BSX_FL_PFX, BSX_AM_DIRECT, 4'h7, 4'h3), 16'h0000, 1'b1);
        chk("rd0", 16'h0000, {15'h0, mem_req.rd});
        done();
        chk("w7", 16'h0001, wreg_view[7]);
        chk("w3", 16'hFFF1, wreg_view[3]);
        chk("c", 16'h0000, {15'h0, carry_flag});
        op(enc(BSX_FR_PFX, BSX_AM_POSTINC, 4'h3, 4'h3), 16'h0004, 1'b1);
        chk("addr3", 16'hFFF1, mem_req.addr);
        done();
        chk("w3", 16'h0003, wreg_view[3]);
    endtask : t_direct
    task automatic t_reset;
        @(posedge sys_clk);
        #1 rst_n = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        chk("w3r", 16'h0000, wreg_view[3]);
        chk("w7r", 16'h0000, wreg_view[7]);
        chk("cr", 16'h0000, {15'h0, carry_flag});
        chk("lr", 16'h0000, last_result);
        sc(BSX_FR_PFX, 16'h0004, 16'h0003, 1'b0);
    endtask : t_reset
    initial begin
        repeat (20) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        for (int i = 0; i < 16; i++) chk("wreg", 16'h0000, wreg_view[i]);
        chk("c0", 16'h0000, {15'h0, carry_flag});
        sc(BSX_FL_PFX, 16'h000A, 16'h000D, 1'b0);
        sc(BSX_FL_PFX, 16'h0000, 16'h0000, 1'b1);
        sc(BSX_FL_PFX, 16'h8000, 16'h0001, 1'b0);
        sc(BSX_FL_PFX, 16'h0001, 16'h0010, 1'b0);
        sc(BSX_FR_PFX, 16'h000A, 16'h0002, 1'b0);
        sc(BSX_FR_PFX, 16'h0000, 16'h0000, 1'b1);
        sc(BSX_FR_PFX, 16'h8000, 16'h0010, 1'b0);
        sc(BSX_FR_PFX, 16'h0001, 16'h0001, 1'b0);
        sc(BSX_SCL_PFX, 16'h55FF, 16'h0000, 1'b0);
        sc(BSX_SCL_PFX, 16'hFFFF, 16'hFFF1, 1'b1);
        sc(BSX_SCL_PFX, 16'hFF0A, 16'hFFF9, 1'b0);
        sc(BSX_SCL_PFX, 16'h0001, 16'hFFF2, 1'b0);
        sc(BSX_SCL_PFX, 16'h0000, 16'hFFF1, 1'b1);
        pt(BSX_AM_POSTINC, 16'h0000, 16'h0002);
        pt(BSX_AM_PREINC, 16'h0004, 16'h0004);
        pt(BSX_AM_POSTDEC, 16'h0004, 16'h0002);
        pt(BSX_AM_PREDEC, 16'h0000, 16'h0000);
        sc(BSX_SCL_PFX, 16'h0000, 16'hFFF1, 1'b1);
        t_swap();
        t_direct();
        t_reset();
        end_of_test();
    end
endmodule : testbench
